// ==== rtl/bus_cycle_if.sv ====
// Pin-level bus-cycle sequencer and interrupt front end of the processor
module bus_cycle_if (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire bus_cycle_pkg::cyc_req_t req,
  input wire logic [2:0] psw_priority,
  input wire bus_cycle_pkg::pin_in_t pins,
  input wire logic [bus_cycle_pkg::DATA_W-1:0] multiplexed_address_data_bus_in,
  output logic req_ready,
  output bus_cycle_pkg::cyc_rsp_t rsp,
  output bus_cycle_pkg::intr_t intr,
  output logic [3:0] transaction_type_code,
  output logic bank_select_upper,
  output logic bank_select_lower,
  output logic address_latch_strobe_n,
  output logic stretch_control_n,
  output logic cycle_strobe_n,
  output logic buffer_direction_n,
  output logic predecode_strobe_n,
  output logic run_indicator_n,
  output logic io_map_enable_n,
  output logic [bus_cycle_pkg::ADDR_W-1:0] multiplexed_address_data_bus_out,
  output logic multiplexed_address_data_bus_oe,
  output logic abort_line_out,
  output logic abort_line_oe
);
  import bus_cycle_pkg::*;

  pin_in_t sync1_r;
  pin_in_t sync2_r;
  cyc_state_t state_r;
  cyc_state_t state_nxt;
  cyc_req_t cmd_r;
  logic dma_next_r;
  logic dma_cur_r;
  logic only_dma_r;

  // Pin inputs pass two flip-flops
  always_ff @(posedge clk) begin
    sync1_r <= pins;
    sync2_r <= sync1_r;
  end

  wire held_rst = rst | ~sync2_r.processor_dc_ok;
  wire start = (state_r == S_IDLE) & req_valid;
  // Fresh request steers the pins on the edge that takes it
  wire cyc_req_t cur = start ? req : cmd_r;

  // Type decode; bit 0 never used for writes
  wire is_read = cmd_r.cyc_type[TT_DIR_BIT];
  wire is_nop = cmd_r.cyc_type == TT_NOP;
  wire is_gp_read = cmd_r.cyc_type == TT_GP_READ;
  wire is_iack = cmd_r.cyc_type == TT_IACK;
  wire is_bus_read = is_read & ~is_nop & ~is_gp_read & ~is_iack;
  wire is_write = ~is_read;
  wire is_gp_write = is_write & cmd_r.cyc_type[TT_GP_BIT];
  wire is_byte_write = is_write & cmd_r.cyc_type[TT_BYTE_BIT];

  // Address class from physical address
  wire in_sys_reg = (cur.addr >= SYS_REG_LO) &
                    (cur.addr <= SYS_REG_HI);
  wire [1:0] addr_class = cur.internal_reg ? BS_INT_REG :
                          (cur.addr < MEM_LIMIT) ? BS_MEMORY :
                          in_sys_reg ? BS_SYS_REG : BS_EXT_IO;

  // Stretch decision at the third period
  wire read_hit = is_bus_read & (addr_class == BS_MEMORY) &
                  ~cmd_r.bypass & ~cmd_r.force_miss &
                  sync2_r.cache_miss_in_n;
  wire need_stretch = dma_cur_r | is_write | is_gp_read | is_iack |
                      (is_bus_read & ~read_hit);
  wire abort_seen = ~sync2_r.abort_line_n |
                    ~sync2_r.parity_error_in_n;
  wire in_cycle = (state_r == S_T2) | (state_r == S_T3) |
                  (state_r == S_STRETCH);
  wire cont = ~sync2_r.continue_in_n;
  wire dv = ~sync2_r.data_valid_in_n & is_read & ~is_nop & ~only_dma_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (req_valid) begin
          state_nxt = S_T1;
        end
      end
      S_T1: state_nxt = S_T2;
      S_T2: state_nxt = abort_seen ? S_END : S_T3;
      S_T3: begin
        if (abort_seen) begin
          state_nxt = S_END;
        end else if (need_stretch) begin
          state_nxt = S_STRETCH;
        end else begin
          state_nxt = S_END;
        end
      end
      S_STRETCH: begin
        if (abort_seen | cont) begin
          state_nxt = S_END;
        end
      end
      S_END: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // Pin output next values
  wire in_first = (state_nxt == S_T1) | (state_nxt == S_T2);
  wire in_second = (state_nxt == S_T3) | (state_nxt == S_STRETCH);
  wire active_nxt = in_first | in_second;
  wire [1:0] bs_nxt = in_first ? addr_class :
                      in_second ? {cmd_r.bypass, cmd_r.force_miss} :
                      BS_MEMORY;
  wire take_in = is_read & ~is_nop & (state_nxt == S_STRETCH);
  wire drive_addr = state_nxt == S_T1;
  wire drive_data = is_write & in_cycle & (state_nxt != S_END);
  wire [ADDR_W-1:0] multiplexed_address_data_bus_nxt =
    drive_addr ? cur.addr :
    {{(ADDR_W-DATA_W){1'b0}}, cmd_r.wdata};

  always_ff @(posedge clk) begin
    if (held_rst) begin
      state_r <= S_IDLE;
      cmd_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        cmd_r <= req;
      end
    end
  end

  // DMA stall sampled at each cycle start, applied to the next
  always_ff @(posedge clk) begin
    if (held_rst) begin
      dma_next_r <= 1'b0;
      dma_cur_r <= 1'b0;
      only_dma_r <= 1'b0;
      io_map_enable_n <= 1'b1;
    end else begin
      if (state_r == S_T1) begin
        dma_next_r <= ~sync2_r.dma_stall_request_n;
      end
      if (start) begin
        dma_cur_r <= dma_next_r;
        dma_next_r <= 1'b0;
      end
      if (state_r == S_T3) begin
        only_dma_r <= read_hit & dma_cur_r;
      end else if (state_r == S_IDLE) begin
        only_dma_r <= 1'b0;
      end
      io_map_enable_n <= ~(dma_next_r | (dma_cur_r & active_nxt));
    end
  end

  // Cycle classification pins
  always_ff @(posedge clk) begin
    if (held_rst) begin
      transaction_type_code <= TT_NOP;
      bank_select_upper <= 1'b0;
      bank_select_lower <= 1'b0;
    end else begin
      transaction_type_code <= active_nxt ? cur.cyc_type : TT_NOP;
      bank_select_upper <= bs_nxt[1];
      bank_select_lower <= bs_nxt[0];
    end
  end

  // Cycle timing strobes
  always_ff @(posedge clk) begin
    if (held_rst) begin
      address_latch_strobe_n <= 1'b1;
      stretch_control_n <= 1'b1;
      cycle_strobe_n <= 1'b1;
      buffer_direction_n <= 1'b1;
    end else begin
      address_latch_strobe_n <= ~(state_nxt == S_T1);
      stretch_control_n <= ~(state_nxt == S_STRETCH);
      cycle_strobe_n <= ~in_second;
      buffer_direction_n <= ~take_in;
    end
  end

  // Instruction predecode and run indicator
  always_ff @(posedge clk) begin
    if (held_rst) begin
      predecode_strobe_n <= 1'b1;
      run_indicator_n <= 1'b0;
    end else begin
      predecode_strobe_n <= ~(in_first & cur.predecode);
      run_indicator_n <= in_first & cur.predecode;
    end
  end

  // Multiplexed bus output
  always_ff @(posedge clk) begin
    if (held_rst) begin
      multiplexed_address_data_bus_out <= '0;
      multiplexed_address_data_bus_oe <= 1'b0;
    end else begin
      multiplexed_address_data_bus_out <= multiplexed_address_data_bus_nxt;
      multiplexed_address_data_bus_oe <= drive_addr | drive_data;
    end
  end

  // Abort line driven low from the second period of a cycle whose request flags a translation error
  always_ff @(posedge clk) begin
    if (held_rst) begin
      abort_line_out <= 1'b0;
      abort_line_oe <= 1'b0;
    end else begin
      abort_line_out <= 1'b0;
      abort_line_oe <= cmd_r.abort_req & active_nxt &
                       (state_nxt != S_T1);
    end
  end

  // Response to the core
  always_ff @(posedge clk) begin
    if (held_rst) begin
      rsp <= '0;
      req_ready <= 1'b0;
    end else begin
      req_ready <= state_nxt == S_IDLE;
      rsp.done <= state_r == S_END;
      if (start) begin
        rsp.aborted <= 1'b0;
      end else if (in_cycle & abort_seen) begin
        rsp.aborted <= 1'b1;
        rsp.rdata <= '0;
      end else if (state_r == S_T3 & read_hit) begin
        rsp.rdata <= multiplexed_address_data_bus_in;
      end else if (state_r == S_STRETCH & dv) begin
        rsp.rdata <= multiplexed_address_data_bus_in;
      end
    end
  end

  // Interrupt arbitration
  logic [2:0] irq_lvl;
  logic irq_any;
  always_comb begin
    irq_lvl = '0;
    irq_any = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (sync2_r.interrupt_request_levels[i]) begin
        irq_lvl = IRQ_BASE_LEVEL + 3'(i);
        irq_any = 1'b1;
      end
    end
  end

  wire nmi_nxt = ~sync2_r.power_fail_in_n |
                 ~sync2_r.parity_error_in_n |
                 ~sync2_r.float_exception_in_n;
  wire irq_ok = irq_any & (irq_lvl > psw_priority);
  wire trap_nxt = sync2_r.line_clock_event;
  wire halt_nxt = sync2_r.halt_request & ~nmi_nxt & ~irq_ok &
                  ~trap_nxt;

  always_ff @(posedge clk) begin
    if (held_rst) begin
      intr <= '0;
    end else begin
      intr.irq_take <= irq_ok;
      intr.irq_level <= irq_ok ? irq_lvl : 3'h0;
      intr.nmi <= nmi_nxt;
      intr.trap_take <= trap_nxt;
      intr.trap_vector <= trap_nxt ? LINE_CLOCK_VECTOR : 16'h0000;
      intr.halt_take <= halt_nxt;
    end
  end

  wire unused_ok = is_gp_write | is_byte_write;
endmodule

// ==== rtl/bus_cycle_pkg.sv ====
// Constants and carrier types for the processor bus-cycle interface
package bus_cycle_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  // Transaction type codes
  localparam logic [3:0] TT_NOP = 4'hf;
  localparam logic [3:0] TT_GP_READ = 4'he;
  localparam logic [3:0] TT_IACK = 4'hd;
  localparam int TT_DIR_BIT = 3;
  localparam int TT_GP_BIT = 2;
  localparam int TT_BYTE_BIT = 1;
  // Bank select address classes
  localparam logic [1:0] BS_MEMORY = 2'h0;
  localparam logic [1:0] BS_SYS_REG = 2'h1;
  localparam logic [1:0] BS_EXT_IO = 2'h2;
  localparam logic [1:0] BS_INT_REG = 2'h3;
  // Physical address boundaries
  localparam logic [21:0] MEM_LIMIT = 22'h3f0000;
  localparam logic [21:0] SYS_REG_LO = 22'h3fffe0;
  localparam logic [21:0] SYS_REG_HI = 22'h3fffe9;
  // Interrupt levels and trap vector
  localparam logic [2:0] IRQ_BASE_LEVEL = 3'h4;
  localparam logic [15:0] LINE_CLOCK_VECTOR = 16'h0040;
  // Cycle sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_T1 = 3'b001,
    S_T2 = 3'b010,
    S_T3 = 3'b011,
    S_STRETCH = 3'b100,
    S_END = 3'b101
  } cyc_state_t;
  typedef struct packed {
    logic [3:0] cyc_type;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic internal_reg;
    logic bypass;
    logic force_miss;
    logic predecode;
    logic abort_req;
  } cyc_req_t;
  typedef struct packed {
    logic done;
    logic aborted;
    logic [DATA_W-1:0] rdata;
  } cyc_rsp_t;
  typedef struct packed {
    logic cache_miss_in_n;
    logic data_valid_in_n;
    logic continue_in_n;
    logic dma_stall_request_n;
    logic [3:0] interrupt_request_levels;
    logic halt_request;
    logic line_clock_event;
    logic power_fail_in_n;
    logic parity_error_in_n;
    logic float_exception_in_n;
    logic processor_dc_ok;
    logic abort_line_n;
  } pin_in_t;
  typedef struct packed {
    logic irq_take;
    logic [2:0] irq_level;
    logic nmi;
    logic trap_take;
    logic [15:0] trap_vector;
    logic halt_take;
  } intr_t;
endpackage

// ==== sim/bus_cycle_if_asserts.sv ====
// Assertion checker for the bus-cycle interface pins
module bus_cycle_if_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire bus_cycle_pkg::pin_in_t pins,
  input wire bus_cycle_pkg::cyc_rsp_t rsp,
  input wire bus_cycle_pkg::intr_t intr,
  input wire logic [3:0] transaction_type_code,
  input wire logic address_latch_strobe_n,
  input wire logic stretch_control_n,
  input wire logic cycle_strobe_n,
  input wire logic buffer_direction_n,
  input wire logic predecode_strobe_n,
  input wire logic run_indicator_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import bus_cycle_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_go;
    $fell(address_latch_strobe_n);
  endsequence
  sequence s_strb;
    cycle_strobe_n [*2] ##1 !cycle_strobe_n;
  endsequence
  a_ale_once:
    assert property (s_go |=> address_latch_strobe_n) else $error("ale");
  a_strobe_t3:
    assert property (s_go |-> s_strb) else $error("strobe");
  a_pd_two:
    assert property ($fell(predecode_strobe_n) |-> !predecode_strobe_n [*2]
      ##1 predecode_strobe_n) else $error("predecode");
  a_run_inv:
    assert property (run_indicator_n == !predecode_strobe_n)
      else $error("run");
  a_stretch_in:
    assert property (!stretch_control_n |-> !cycle_strobe_n)
      else $error("stretch");
  a_stretch_end:
    assert property (!stretch_control_n && !pins.continue_in_n |->
      ##[0:6] stretch_control_n) else $error("continue");
  a_buf_read:
    assert property (!buffer_direction_n |-> !stretch_control_n &&
      transaction_type_code[3]) else $error("buffer");
  a_done_end:
    assert property ($rose(cycle_strobe_n) |-> ##[0:3] rsp.done)
      else $error("done");
  a_nmi_pins:
    assert property ((!pins.power_fail_in_n || !pins.parity_error_in_n ||
      !pins.float_exception_in_n) [*5] |-> intr.nmi) else $error("nmi");
endmodule

// ==== sim/cache_ctrl_model.sv ====
// Behavioural cache and control-store partner
module cache_ctrl_model (
  input wire logic clk,
  input wire logic stretch_control_n,
  input wire logic buffer_direction_n,
  input wire logic tag_mismatch,
  input wire logic [3:0] wait_cycles,
  input wire logic [15:0] read_word,
  output logic cache_miss_in_n,
  output logic data_valid_in_n,
  output logic continue_in_n,
  output logic [15:0] multiplexed_address_data_bus_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial begin
    {data_valid_in_n, continue_in_n} = 2'b11;
    multiplexed_address_data_bus_in = 16'h0;
  end
  assign cache_miss_in_n = !tag_mismatch;
  always @(posedge clk) begin
    cnt <= stretch_control_n ? 0 : cnt + 1;
    if (stretch_control_n) begin
      {data_valid_in_n, continue_in_n} <= 2'b11;
    end
    if (!stretch_control_n && !buffer_direction_n && cnt == wait_cycles) begin
      data_valid_in_n <= 1'b0;
    end
    if (!stretch_control_n && cnt == wait_cycles + 1) begin
      continue_in_n <= 1'b0;
    end
    multiplexed_address_data_bus_in <= buffer_direction_n ? ~multiplexed_address_data_bus_in : read_word;
  end
endmodule

// ==== sim/test_bus_cycle_if.sv ====
// Self-checking bench for the bus-cycle interface
`define CHK(g, e, m) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("CHECK FAILED %0t %s", $time, m); \
  end \
end
module test_bus_cycle_if;
  timeunit 1ns;
  timeprecision 100ps;
  import bus_cycle_pkg::*;
  logic clk = 0, rst = 1, req_valid = 0, tag_miss = 0, abort_drv = 0;
  logic dma_n = 1, halt = 0, lclk = 0, pf_n = 1, par_n = 1, fpe_n = 1;
  logic [3:0] lvl = 4'h0, waits = 4'h0;
  logic dc_ok = 1, sa_mode = 0, slu_irq = 0, multiplexed_address_data_bus_oe;
  logic [21:0] multiplexed_address_data_bus_out;
  logic [2:0] psw_priority = 3'h0;
  logic [15:0] rw = 16'hc35a, multiplexed_address_data_bus_in;
  logic miss_n, dv_n, cont_n, map_seen, str_seen, buf_seen;
  logic req_ready, address_latch_strobe_n, stretch_control_n;
  logic cycle_strobe_n, buffer_direction_n, predecode_strobe_n;
  logic run_indicator_n, io_map_enable_n, abort_line_out, abort_line_oe;
  logic bank_select_upper, bank_select_lower;
  logic [3:0] transaction_type_code;
  int err_total = 0, num_checks = 0, ticks = 0;
  cyc_req_t req = '0;
  pin_in_t pins;
  cyc_rsp_t rsp;
  intr_t intr;
  wire logic abort_n = !((abort_line_oe && !abort_line_out) || abort_drv);
  wire logic [3:0] irq_pins = (sa_mode ? 4'h0 : lvl) | {3'h0, slu_irq};
  assign pins = {miss_n, dv_n, cont_n, dma_n, irq_pins, halt, lclk, pf_n,
    par_n, fpe_n, dc_ok, abort_n};
  bus_cycle_if bus_cycle_if_inst (.clk, .rst, .req_valid, .req,
    .psw_priority, .pins, .multiplexed_address_data_bus_in, .req_ready, .rsp, .intr,
    .transaction_type_code, .bank_select_upper, .bank_select_lower,
    .address_latch_strobe_n, .stretch_control_n, .cycle_strobe_n,
    .buffer_direction_n, .predecode_strobe_n, .run_indicator_n,
    .io_map_enable_n, .multiplexed_address_data_bus_out, .multiplexed_address_data_bus_oe, .abort_line_out,
    .abort_line_oe);
  cache_ctrl_model cache_ctrl_model_inst (.clk, .stretch_control_n,
    .buffer_direction_n, .tag_mismatch(tag_miss), .wait_cycles(waits),
    .read_word(rw), .cache_miss_in_n(miss_n), .data_valid_in_n(dv_n),
    .continue_in_n(cont_n), .multiplexed_address_data_bus_in);
  always #12.5 clk = ~clk;
  always @(negedge clk) begin
    map_seen |= !io_map_enable_n;
    str_seen |= !stretch_control_n;
    buf_seen |= !buffer_direction_n;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    ticks++;
    if (ticks == 6000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic cyc(input logic [3:0] t, input logic [21:0] a,
                     input logic ir, bp, ab, input logic [1:0] bs);
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    req = '{cyc_type: t, addr: a, wdata: 16'h5a3c, internal_reg: ir,
      bypass: bp, force_miss: 0, predecode: 1, abort_req: 0};
    req_valid = 1'b1;
    {map_seen, str_seen, buf_seen} = 3'b000;
    @(negedge clk);
    req_valid = 1'b0;
    while (address_latch_strobe_n !== 1'b0) @(negedge clk);
    abort_drv = ab;
    `CHK(transaction_type_code, t, "type")
    `CHK({bank_select_upper, bank_select_lower}, bs, "class")
    `CHK(predecode_strobe_n, 1'b0, "predecode")
    `CHK({multiplexed_address_data_bus_oe, multiplexed_address_data_bus_out}, {1'b1, a}, "address")
    while (cycle_strobe_n !== 1'b0) @(negedge clk);
    `CHK({bank_select_upper, bank_select_lower}, {bp, 1'b0}, "hint")
    `CHK(multiplexed_address_data_bus_oe, !t[3], "data drive")
    if (!t[3]) `CHK(multiplexed_address_data_bus_out[15:0], 16'h5a3c, "write data")
    while (rsp.done !== 1'b1) @(negedge clk);
    abort_drv = 1'b0;
    `CHK(rsp.aborted, ab, "abort")
  endtask
  task automatic s_types();
    logic [3:0] tab [14] = '{4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9,
      4'h8, 4'h7, 4'h6, 4'h4, 4'h3, 4'h2, 4'h0};
    logic st;
    foreach (tab[i]) begin
      st = !(tab[i] inside {[4'h8:4'hc], 4'hf});
      cyc(tab[i], 22'h001000, 0, 0, 0, 2'h0);
      `CHK(str_seen, st, "stretch")
      `CHK(buf_seen, st & tab[i][3], "buffer")
    end
  endtask
  task automatic s_class();
    cyc(4'h9, 22'h3effff, 0, 0, 0, 2'h0);
    cyc(4'h9, 22'h3f0000, 0, 0, 0, 2'h2);
    cyc(4'h9, 22'h3fffdf, 0, 0, 0, 2'h2);
    cyc(4'h9, 22'h3fffe0, 0, 0, 0, 2'h1);
    cyc(4'h9, 22'h3fffe9, 0, 0, 0, 2'h1);
    cyc(4'h9, 22'h3fffea, 0, 0, 0, 2'h2);
    cyc(4'h9, 22'h3ffffe, 1, 0, 0, 2'h3);
  endtask
  task automatic s_read();
    cyc(4'h9, 22'h000100, 0, 1, 0, 2'h0);
    `CHK(rsp.rdata, 16'hc35a, "prompt read")
    waits = 4'h6;
    rw = 16'h3ca5;
    cyc(4'h8, 22'h000102, 0, 1, 0, 2'h0);
    `CHK(rsp.rdata, 16'h3ca5, "slow read")
    cyc(4'h9, 22'h000104, 0, 1, 1, 2'h0);
    `CHK(rsp.rdata, 16'h0000, "aborted data")
    tag_miss = 1'b1;
    cyc(4'h9, 22'h000106, 0, 0, 0, 2'h0);
    `CHK({str_seen, rsp.rdata}, {1'b1, 16'h3ca5}, "miss read")
    tag_miss = 1'b0;
  endtask
  task automatic pin_chk(input logic [3:0] l, input logic h,
                         input logic [1:0] e, input logic [2:0] lv);
    lvl = l;
    halt = h;
    repeat (6) @(negedge clk);
    `CHK({intr.irq_take, intr.halt_take}, e, "take")
    if (e[1]) `CHK(intr.irq_level, lv, "level")
  endtask
  task automatic s_irq();
    psw_priority = 3'h5;
    pin_chk(4'h2, 0, 2'b00, 3'h0);
    pin_chk(4'h4, 0, 2'b10, 3'h6);
    pin_chk(4'h0, 1, 2'b01, 3'h0);
    pin_chk(4'h8, 1, 2'b10, 3'h7);
    pin_chk(4'h0, 0, 2'b00, 3'h0);
    lclk = 1'b1;
    repeat (6) @(negedge clk);
    `CHK({intr.trap_take, intr.trap_vector}, 17'h10040, "trap")
    lclk = 1'b0;
    for (int i = 0; i < 3; i++) begin
      {pf_n, par_n, fpe_n} = ~(3'b100 >> i);
      repeat (6) @(negedge clk);
      `CHK(intr.nmi, 1'b1, "nmi")
    end
    {pf_n, par_n, fpe_n} = 3'b111;
    psw_priority = 3'h3;
    sa_mode = 1'b1;
    slu_irq = 1'b1;
    pin_chk(4'h8, 0, 2'b10, 3'h4);
    {sa_mode, slu_irq} = 2'b00;
    pin_chk(4'h0, 0, 2'b00, 3'h0);
  endtask
  task automatic s_dma();
    dma_n = 1'b0;
    cyc(4'h8, 22'h000200, 0, 0, 0, 2'h0);
    dma_n = 1'b1;
    cyc(4'h8, 22'h000202, 0, 0, 0, 2'h0);
    `CHK({map_seen, str_seen}, 2'b11, "dma stall")
  endtask
  task automatic s_power();
    dc_ok = 1'b0;
    repeat (4) @(negedge clk);
    `CHK({req_ready, rsp.done}, 2'b00, "dc ok reset")
    dc_ok = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(req_ready, 1'b1, "dc ok release")
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK(transaction_type_code, TT_NOP, "idle type")
    s_types();
    s_class();
    s_read();
    s_irq();
    s_dma();
    s_power();
    complete_run();
  end
endmodule
bind bus_cycle_if bus_cycle_if_asserts bus_cycle_if_asserts_inst (.clk,
  .rst, .pins, .rsp, .intr, .transaction_type_code,
  .address_latch_strobe_n, .stretch_control_n, .cycle_strobe_n,
  .buffer_direction_n, .predecode_strobe_n, .run_indicator_n);
